// ### converter_control_regs.sv
// Converter setup and fault response register bank with power control state.
`timescale 1ns/1ps
`default_nettype none
`include "conv_regs_map.svh"
module converter_control_regs #(
  parameter logic OTP_OVERRIDE = 1'b0,
  parameter longint unsigned HICCUP_CYCLES = `HICCUP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Enable pin and fault
  input wire logic enable_pin,
  input wire logic overcurrent,
  // Register access from the serial slave
  input wire logic wr_stb,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_stb,
  input wire logic [7:0] rd_addr,
  input wire logic stop_valid_write,
  // Register read answer
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Power stage control
  output logic serial_awake,
  output logic converter_on,
  output logic bypass_on,
  output logic pwm_forced,
  output logic drain_on,
  output logic amp_type2,
  output logic current_limit_only,
  output logic [1:0] slope_out,
  output logic [7:0] level_out,
  output logic reconfig_pulse
);
  logic [7:0] setup_r, setup_nxt;
  logic [7:0] fault_r, fault_nxt;
  logic [7:0] target_r, target_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic en_d_r, en_d_nxt;
  logic otp_done_r, otp_done_nxt;
  logic [63:0] wait_r, wait_nxt;
  conv_regs_pkg::pwr_state_t st_r, st_nxt;
  logic awake_r, awake_nxt, conv_r, conv_nxt, byp_r, byp_nxt, pwm_r, pwm_nxt;
  logic drain_r, drain_nxt, amp_r, amp_nxt, lim_r, lim_nxt, reconf_r, reconf_nxt;
  logic [1:0] slope_r, slope_nxt;
  logic [7:0] ramp_level;
  logic enabled, run_req, en_rise, run_write;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Override means the pin is ignored, so a released button leaves the part up.
  assign enabled = fault_r[`FR_OVERRIDE_BIT] | enable_pin;
  assign run_req = enabled & setup_r[`CS_RUN_BIT];
  assign en_rise = enable_pin & ~en_d_r;
  assign run_write = wr_stb & enabled & (wr_addr == `OFS_CONVERTER_SETUP) & wr_data[`CS_RUN_BIT];

  always_comb begin
    setup_nxt = setup_r;
    fault_nxt = fault_r;
    target_nxt = target_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    en_d_nxt = enable_pin;
    otp_done_nxt = 1'b1;
    // The serial side is asleep while disabled, so accesses then are dropped.
    if (wr_stb & enabled) begin
      case (wr_addr)
        `OFS_OUTPUT_LEVEL: target_nxt = wr_data;
        `OFS_CONVERTER_SETUP: setup_nxt = wr_data;
        `OFS_FAULT_RESPONSE: fault_nxt = {wr_data[7:5], 5'h00};
        default: ;
      endcase
    end
    // The programmed override lands once after release, so a push-button part stays up when the pin drops.
    if (OTP_OVERRIDE && !otp_done_r) begin
      fault_nxt[`FR_OVERRIDE_BIT] = 1'b1;
    end
    if (rd_stb & enabled) begin
      rd_valid_nxt = 1'b1;
      case (rd_addr)
        `OFS_OUTPUT_LEVEL: rd_data_nxt = target_r;
        `OFS_CONVERTER_SETUP: rd_data_nxt = setup_r;
        `OFS_FAULT_RESPONSE: rd_data_nxt = fault_r;
        default: rd_data_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      setup_r <= `CONVERTER_SETUP_RST;
      fault_r <= `FAULT_RESPONSE_RST;
      target_r <= `OUTPUT_LEVEL_RST;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
      en_d_r <= 1'b0;
      otp_done_r <= 1'b0;
    end else begin
      setup_r <= setup_nxt;
      fault_r <= fault_nxt;
      target_r <= target_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      en_d_r <= en_d_nxt;
      otp_done_r <= otp_done_nxt;
    end
  end

  // ----------------------------------------
  // Power control
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    wait_nxt = wait_r;
    case (st_r)
      conv_regs_pkg::PWR_OFF: begin
        if (run_req) st_nxt = conv_regs_pkg::PWR_RUN;
      end
      conv_regs_pkg::PWR_RUN: begin
        if (!run_req) begin
          st_nxt = conv_regs_pkg::PWR_OFF;
        end else if (overcurrent) begin
          case (conv_regs_pkg::ovl_mode_t'(fault_r[`FR_OVL_HI:`FR_OVL_LO]))
            conv_regs_pkg::OVL_HICCUP: begin
              st_nxt = conv_regs_pkg::PWR_HICCUP;
              wait_nxt = 64'h0;
            end
            conv_regs_pkg::OVL_SHUTDOWN: st_nxt = conv_regs_pkg::PWR_LATCHED;
            default: ;
          endcase
        end
      end
      conv_regs_pkg::PWR_HICCUP: begin
        if (!run_req) begin
          st_nxt = conv_regs_pkg::PWR_OFF;
        end else if (wait_r + 64'h1 >= HICCUP_CYCLES) begin
          st_nxt = conv_regs_pkg::PWR_RUN;
        end else begin
          wait_nxt = wait_r + 64'h1;
        end
      end
      conv_regs_pkg::PWR_LATCHED: begin
        // Only a run write or a fresh pin edge restarts; a still-high pin does not.
        if (!enabled) st_nxt = conv_regs_pkg::PWR_OFF;
        else if (run_write | en_rise) st_nxt = conv_regs_pkg::PWR_RUN;
      end
      default: st_nxt = conv_regs_pkg::PWR_OFF;
    endcase
  end

  always_comb begin
    awake_nxt = enabled;
    conv_nxt = (st_nxt == conv_regs_pkg::PWR_RUN);
    // Bypass survives a run bit clear but not a dead pin.
    byp_nxt = enabled & (setup_r[`CS_FORCED_HI:`CS_FORCED_LO] == 2'(conv_regs_pkg::MODE_BYPASS));
    if (byp_nxt) conv_nxt = 1'b0;
    pwm_nxt = conv_nxt & (setup_r[`CS_FORCED_HI:`CS_FORCED_LO] == 2'(conv_regs_pkg::MODE_PWM));
    drain_nxt = enabled & ~setup_r[`CS_RUN_BIT] & setup_r[`CS_DRAIN_BIT] & ~byp_nxt;
    amp_nxt = setup_r[`CS_AMP_BIT];
    lim_nxt = fault_r[`FR_OVL_HI];
    slope_nxt = setup_r[`CS_SLOPE_HI:`CS_SLOPE_LO];
    reconf_nxt = stop_valid_write & enabled;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= conv_regs_pkg::PWR_OFF;
      wait_r <= 64'h0;
      awake_r <= 1'b0;
      conv_r <= 1'b0;
      byp_r <= 1'b0;
      pwm_r <= 1'b0;
      drain_r <= 1'b0;
      amp_r <= 1'b1;
      lim_r <= 1'b0;
      slope_r <= 2'h0;
      reconf_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      wait_r <= wait_nxt;
      awake_r <= awake_nxt;
      conv_r <= conv_nxt;
      byp_r <= byp_nxt;
      pwm_r <= pwm_nxt;
      drain_r <= drain_nxt;
      amp_r <= amp_nxt;
      lim_r <= lim_nxt;
      slope_r <= slope_nxt;
      reconf_r <= reconf_nxt;
    end
  end

  // ----------------------------------------
  // Output level ramp
  // ----------------------------------------
  level_ramp u_ramp (
    .clk(clk),
    .rst(rst),
    .target(target_r),
    .slope(setup_r[`CS_SLOPE_HI:`CS_SLOPE_LO]),
    .level(ramp_level),
    .busy()
  );

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign serial_awake = awake_r;
  assign converter_on = conv_r;
  assign bypass_on = byp_r;
  assign pwm_forced = pwm_r;
  assign drain_on = drain_r;
  assign amp_type2 = amp_r;
  assign current_limit_only = lim_r;
  assign slope_out = slope_r;
  assign level_out = ramp_level;
  assign reconfig_pulse = reconf_r;
endmodule // converter_control_regs
`default_nettype wire

// ### conv_regs_map.svh
// Register offsets, field positions, reset values and timing counts of the converter control bank.
`ifndef CONV_REGS_MAP_SVH
`define CONV_REGS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_OUTPUT_LEVEL 8'h11
`define OFS_CONVERTER_SETUP 8'h12
`define OFS_FAULT_RESPONSE 8'h13

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CS_RUN_BIT 7
`define CS_DRAIN_BIT 6
`define CS_SLOPE_HI 5
`define CS_SLOPE_LO 4
`define CS_FORCED_HI 3
`define CS_FORCED_LO 2
`define CS_SPARE_BIT 1
`define CS_AMP_BIT 0
`define FR_OVL_HI 7
`define FR_OVL_LO 6
`define FR_OVERRIDE_BIT 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CONVERTER_SETUP_RST 8'h81
`define FAULT_RESPONSE_RST 8'h00
`define OUTPUT_LEVEL_RST 8'h84

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_PS 5000
`define HICCUP_WAIT_MS 100
`define HICCUP_CYCLES ((`HICCUP_WAIT_MS * 64'd1000000000) / `CLK_PERIOD_PS)
// Picoseconds for a 25 mV step at 3.125 mV/us, the slope code 0 time; others scale from it.
`define STEP_MV 25
`define STEP_PS_CODE0 ((`STEP_MV * 64'd1000000000) / 3125)
`define STEP_CYCLES_CODE0 (`STEP_PS_CODE0 / `CLK_PERIOD_PS)

`endif

// ### conv_regs_pkg.sv
// Types shared by the converter control bank.
package conv_regs_pkg;
  typedef enum logic [1:0] {MODE_AUTO, MODE_RSVD, MODE_PWM, MODE_BYPASS} forced_mode_t;
  typedef enum logic [1:0] {OVL_HICCUP, OVL_SHUTDOWN, OVL_LIMIT, OVL_RSVD} ovl_mode_t;
  typedef enum {PWR_OFF, PWR_RUN, PWR_HICCUP, PWR_LATCHED} pwr_state_t;
endpackage

// ### level_ramp.sv
// Output level ramp that walks the target in 25 mV steps at the selected slope.
`timescale 1ns/1ps
`default_nettype none
`include "conv_regs_map.svh"
module level_ramp #(
  parameter int unsigned STEP_CYCLES = 32'(`STEP_CYCLES_CODE0)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Target and slope
  input wire logic [7:0] target,
  input wire logic [1:0] slope,
  // Ramped output
  output logic [7:0] level,
  output logic busy
);
  logic [7:0] level_r, level_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;

  // Code 0 is 3.125, 1 is twice as fast, 2 a quarter, 3 half.
  function automatic logic [31:0] step_len(input logic [1:0] s);
    case (s)
      2'h0: step_len = 32'(STEP_CYCLES);
      2'h1: step_len = 32'(STEP_CYCLES / 2);
      2'h2: step_len = 32'(STEP_CYCLES * 4);
      default: step_len = 32'(STEP_CYCLES * 2);
    endcase
  endfunction

  always_comb begin
    level_nxt = level_r;
    cnt_nxt = cnt_r;
    busy_nxt = (level_r != target);
    if (level_r == target) begin
      cnt_nxt = 32'h0;
    end else if (cnt_r + 32'h1 >= step_len(slope)) begin
      cnt_nxt = 32'h0;
      level_nxt = (level_r < target) ? level_r + 8'h01 : level_r - 8'h01;
    end else begin
      cnt_nxt = cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_r <= `OUTPUT_LEVEL_RST;
      cnt_r <= 32'h0;
      busy_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign level = level_r;
  assign busy = busy_r;
endmodule // level_ramp
`default_nettype wire

// ### conv_host_model.sv
// Serial slave side model that hands register strobes to the bank.
`timescale 1ns/1ps
`default_nettype none
module conv_host_model (
  // Clock
  input wire logic clk,
  // Strobes to the bank
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_stb,
  output logic [7:0] rd_addr,
  output logic stop_valid_write,
  // Read answer
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    {wr_stb, rd_stb, stop_valid_write} = 3'h0;
    {wr_addr, wr_data, rd_addr} = 24'h0;
  end
  // Released fields are inverted so that stale data is never mistaken for held data.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input logic stop);
    @(negedge clk);
    wr_stb = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_stb = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
    stop_valid_write = stop;
    @(negedge clk);
    stop_valid_write = 1'b0;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk);
    rd_stb = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_stb = 1'b0;
    rd_addr = ~a;
    ok = rd_valid;
    d = rd_data;
  endtask
endmodule  // conv_host_model
`default_nettype wire

// ### converter_control_regs_monitor.sv
// Port checker for the converter control bank.
`timescale 1ns/1ps
`default_nettype none
module converter_control_regs_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests
  input wire logic rd_stb,
  input wire logic [7:0] rd_addr,
  input wire logic wr_stb,
  input wire logic [7:0] wr_addr,
  input wire logic stop_valid_write,
  // Answers
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic serial_awake,
  input wire logic converter_on,
  input wire logic bypass_on,
  input wire logic pwm_forced,
  input wire logic drain_on,
  input wire logic amp_type2,
  input wire logic [1:0] slope_out,
  input wire logic [7:0] level_out,
  input wire logic reconfig_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_recfg_end;
    !reconfig_pulse || $past(stop_valid_write);
  endsequence
  property p_rd_ans; rd_valid |-> $past(rd_stb); endproperty
  property p_unmapped; rd_valid && !($past(rd_addr) inside {8'h11, 8'h12, 8'h13}) |-> rd_data == 8'h00; endproperty
  property p_reconfig; reconfig_pulse |-> $past(stop_valid_write) ##1 s_recfg_end; endproperty
  property p_bypass; bypass_on |-> !converter_on && !pwm_forced; endproperty
  property p_drain; drain_on |-> !converter_on && !bypass_on && serial_awake; endproperty
  property p_asleep; !serial_awake |-> !converter_on && !bypass_on; endproperty
  property p_cfg; $changed({slope_out, amp_type2}) |-> $past(wr_stb, 2) && $past(wr_addr, 2) == 8'h12; endproperty
  property p_step; $changed(level_out) |-> level_out - $past(level_out) inside {8'h01, 8'hFF}; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer without request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_reconfig: assert property (p_reconfig) else $error("reconfig pulse without stop");
  a_bypass: assert property (p_bypass) else $error("bypass while switching");
  a_drain: assert property (p_drain) else $error("drain while running");
  a_asleep: assert property (p_asleep) else $error("running while asleep");
  a_cfg: assert property (p_cfg) else $error("setup outputs moved without write");
  a_step: assert property (p_step) else $error("level moved by more than a step");
endmodule  // converter_control_regs_monitor
`default_nettype wire

// ### tb.sv
// Self-checking bench for the converter control bank.
`timescale 1ns/1ps
`default_nettype none
`include "conv_regs_map.svh"
module tb;
  logic clk, rst, enable_pin, overcurrent, wr_stb, rd_stb, stop_valid_write, rd_valid, reconfig_pulse;
  logic serial_awake, converter_on, bypass_on, pwm_forced, drain_on, amp_type2, current_limit_only;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data, level_out;
  logic [1:0] slope_out;
  logic otp_awake;
  int n_errors = 0;
  int samples_checked = 0;
  converter_control_regs #(.HICCUP_CYCLES(20)) i_dut (.clk, .rst, .enable_pin, .overcurrent, .wr_stb,
    .wr_addr, .wr_data, .rd_stb, .rd_addr, .stop_valid_write, .rd_data, .rd_valid, .serial_awake,
    .converter_on, .bypass_on, .pwm_forced, .drain_on, .amp_type2, .current_limit_only, .slope_out,
    .level_out, .reconfig_pulse);
  converter_control_regs #(.OTP_OVERRIDE(1'b1), .HICCUP_CYCLES(20)) i_dut_otp (.clk, .rst, .enable_pin,
    .overcurrent, .wr_stb, .wr_addr, .wr_data, .rd_stb, .rd_addr, .stop_valid_write, .rd_data(), .rd_valid(),
    .serial_awake(otp_awake), .converter_on(), .bypass_on(), .pwm_forced(), .drain_on(), .amp_type2(),
    .current_limit_only(), .slope_out(), .level_out(), .reconfig_pulse());
  conv_host_model i_host (.clk, .wr_stb, .wr_addr, .wr_data, .rd_stb, .rd_addr, .stop_valid_write,
    .rd_data, .rd_valid);
  task automatic print_verdict;
    $display("checked=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.write_reg(a, d, 1'b1);
    repeat (3) @(negedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic ok_exp);
    logic [7:0] d;
    logic ok;
    i_host.read_reg(a, d, ok);
    chk({7'h0, ok}, {7'h0, ok_exp});
    if (ok_exp) chk(d, exp);
  endtask
  task automatic wait_on(input logic v, input int lim);
    for (int i = 0; i < lim && converter_on !== v; i++) @(negedge clk);
    chk({7'h0, converter_on}, {7'h0, v});
    if (converter_on !== v) print_verdict;
  endtask
  task automatic oc_pulse;
    overcurrent = 1'b1;
    repeat (2) @(negedge clk);
    overcurrent = 1'b0;
  endtask
  task automatic t_reset;
    rd_chk(8'h12, 8'h81, 1'b1);
    rd_chk(8'h13, 8'h00, 1'b1);
    rd_chk(8'h11, 8'h84, 1'b1);
    rd_chk(8'h20, 8'h00, 1'b1);
    chk({6'h0, converter_on, amp_type2}, 8'h03);
    $display("test reset done");
  endtask
  task automatic t_run;
    wr(8'h12, 8'h41);
    chk({6'h0, converter_on, drain_on}, 8'h01);
    wr(8'h12, 8'hC1);
    chk({6'h0, converter_on, drain_on}, 8'h02);
    enable_pin = 1'b0;
    repeat (4) @(negedge clk);
    chk({6'h0, serial_awake, converter_on}, 8'h00);
    chk({7'h0, otp_awake}, 8'h01);
    rd_chk(8'h12, 8'h00, 1'b0);
    enable_pin = 1'b1;
    wait_on(1'b1, 10);
    $display("test run done");
  endtask
  task automatic t_modes;
    wr(8'h12, 8'h89);
    chk({7'h0, pwm_forced}, 8'h01);
    wr(8'h12, 8'h8D);
    chk({6'h0, bypass_on, converter_on}, 8'h02);
    wr(8'h12, 8'h0D);
    chk({6'h0, bypass_on, converter_on}, 8'h02);
    for (int s = 0; s < 4; s++) begin
      wr(8'h12, {2'h2, 2'(s), 4'h0});
      chk({4'h0, slope_out, 1'b0, amp_type2}, {4'h0, 2'(s), 2'h0});
    end
    $display("test modes done");
  endtask
  task automatic t_fault;
    wr(8'h13, 8'h9F);
    rd_chk(8'h13, 8'h80, 1'b1);
    chk({7'h0, current_limit_only}, 8'h01);
    wr(8'h13, 8'h40);
    oc_pulse;
    wait_on(1'b0, 10);
    repeat (40) @(negedge clk);
    chk({7'h0, converter_on}, 8'h00);
    wr(8'h12, 8'h80);
    wait_on(1'b1, 10);
    wr(8'h13, 8'h00);
    oc_pulse;
    wait_on(1'b0, 10);
    repeat (10) @(negedge clk);
    chk({7'h0, converter_on}, 8'h00);
    repeat (8) @(negedge clk);
    chk({7'h0, converter_on}, 8'h00);
    @(negedge clk);
    chk({7'h0, converter_on}, 8'h01);
    wait_on(1'b1, 40);
    $display("test fault done");
  endtask
  task automatic t_override;
    wr(8'h13, 8'h20);
    enable_pin = 1'b0;
    repeat (4) @(negedge clk);
    chk({6'h0, serial_awake, converter_on}, 8'h03);
    rd_chk(8'h13, 8'h20, 1'b1);
    wr(8'h13, 8'h00);
    chk({7'h0, serial_awake}, 8'h00);
    enable_pin = 1'b1;
    wait_on(1'b1, 10);
    $display("test override done");
  endtask
  task automatic t_ramp;
    int n;
    i_host.write_reg(8'h11, 8'h86, 1'b1);
    chk({7'h0, reconfig_pulse}, 8'h01);
    chk(level_out, 8'h84);
    for (n = 0; n < 2000 && level_out !== 8'h85; n++) @(negedge clk);
    chk(level_out, 8'h85);
    for (n = 0; n < 2000 && level_out !== 8'h86; n++) @(negedge clk);
    chk(level_out, 8'h86);
    samples_checked++;
    if (n != int'(`STEP_CYCLES_CODE0)) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, n, int'(`STEP_CYCLES_CODE0));
    end
    if (level_out !== 8'h86) print_verdict;
    $display("test ramp done");
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    enable_pin = 1'b1;
    overcurrent = 1'b0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_run;
    t_modes;
    t_fault;
    t_override;
    t_ramp;
    print_verdict;
  end
endmodule  // tb
bind converter_control_regs converter_control_regs_monitor i_mon (.clk, .rst, .rd_stb, .rd_addr, .wr_stb,
  .wr_addr, .stop_valid_write, .rd_data, .rd_valid, .serial_awake, .converter_on, .bypass_on, .pwm_forced,
  .drain_on, .amp_type2, .slope_out, .level_out, .reconfig_pulse);
`default_nettype wire
